// file: logic/sesq_top.sv
/*
 * Excitation sequencer of a unipolar two-phase stepper driver with an
 * AXI4-Lite register slave. Pins are synchronised, steps advance a
 * four-quadrant position, and the position sets drive and current codes.
 * Assumes the step, direction, mode, enable and reset pins are asynchronous
 * levels and that the step clock is far slower than aclk.
 */
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
// What this block does
// - With edge select high, steps happen on rising step-clock edges only, modes full, half 100, quarter, eighth.
// - With edge select low, steps happen on both edges, modes half pseudo-micro, quarter, eighth, sixteenth.
// - Half step on rising edges gives full current at every position.
// - Half step on both edges alternates phase current between 100 and 71 percent.
// - The sixteenth angle maps to the percentages 11 through 100, coarser modes use a subset.
// - Enable low forces all four drive outputs off.
// - 100 percent is the software-set peak code and other levels scale from it.
// - Direction low steps forward (clockwise), high steps backward.
// - Enable low freezes position and mode and ignores all pins except reset; the register port still works.
`timescale 1ns/1ns
module sesq_top
  import sesq_pkg::*;
(
  input  wire logic              aclk,              // 20 MHz system clock
  input  wire logic              aresetn,           // Synchronous reset, power-on
  input  wire logic              step_clock_in,     // Step clock pin
  input  wire logic              rotation_direction_in, // Direction pin
  input  wire logic              mode_sel_low_bit,  // Mode pin, low bit
  input  wire logic              mode_sel_high_bit, // Mode pin, high bit
  input  wire logic              edge_select_bit,   // Edge select pin
  input  wire logic              output_enable_in,  // Output enable pin, high runs
  input  wire logic              system_reset_n_in, // Reset pin, low active
  output logic                   drive_a,           // Winding A on
  output logic                   drive_ab,          // Winding A complement on
  output logic                   drive_b,           // Winding B on
  output logic                   drive_bb,          // Winding B complement on
  output logic      [7:0]        current_a_code,    // Chopper level phase A
  output logic      [7:0]        current_b_code,    // Chopper level phase B
  input  wire logic              s_axi_awvalid,     // Write address valid
  output logic                   s_axi_awready,     // Write address ready
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,      // Write address
  input  wire logic              s_axi_wvalid,      // Write data valid
  output logic                   s_axi_wready,      // Write data ready
  input  wire logic [31:0]       s_axi_wdata,       // Write data
  input  wire logic [3:0]        s_axi_wstrb,       // Byte enables
  output logic                   s_axi_bvalid,      // Write response valid
  input  wire logic              s_axi_bready,      // Write response ready
  output logic      [1:0]        s_axi_bresp,       // Write response
  input  wire logic              s_axi_arvalid,     // Read address valid
  output logic                   s_axi_arready,     // Read address ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,      // Read address
  output logic                   s_axi_rvalid,      // Read data valid
  input  wire logic              s_axi_rready,      // Read data ready
  output logic      [31:0]       s_axi_rdata,       // Read data
  output logic      [1:0]        s_axi_rresp        // Read response
);
  import sesq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic sesq_mode_t decode_mode(input logic e, input logic hi, input logic lo);
    case ({e, hi, lo})
      3'h4:    decode_mode = EX_FULL;
      3'h5:    decode_mode = EX_HALF100;
      3'h6:    decode_mode = EX_QUARTER;
      3'h7:    decode_mode = EX_EIGHTH;
      3'h0:    decode_mode = EX_HALFPM;
      3'h1:    decode_mode = EX_QUARTER;
      3'h2:    decode_mode = EX_EIGHTH;
      default: decode_mode = EX_SIXTEENTH;
    endcase
  endfunction

  function automatic logic [5:0] step_of(input sesq_mode_t m);
    case (m)
      EX_FULL:    step_of = STEP_FULL;
      EX_HALF100: step_of = STEP_HALF;
      EX_HALFPM:  step_of = STEP_HALF;
      EX_QUARTER: step_of = STEP_QUART;
      EX_EIGHTH:  step_of = STEP_EIGHT;
      default:    step_of = STEP_SIXT;
    endcase
  endfunction

  // Percent of peak; the divide is by a constant so it folds to logic
  function automatic logic [7:0] scale(input logic [7:0] peak, input logic [6:0] pct);
    logic [14:0] prod;
    prod  = peak * pct;
    scale = 8'(prod / PCT_DIV);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [SYNC_W-1:0] pins_s;
  logic              clk_s;
  logic              dir_s;
  logic              lo_s;
  logic              hi_s;
  logic              edge_s;
  logic              en_s;
  logic              rstpin_n_s;

  sesq_sync #(.W(SYNC_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({system_reset_n_in, output_enable_in, edge_select_bit, mode_sel_high_bit,
               mode_sel_low_bit, rotation_direction_in, step_clock_in}),
    .dout    (pins_s)
  );

  assign {rstpin_n_s, en_s, edge_s, hi_s, lo_s, dir_s, clk_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer core

  logic        soft_rst_reg;
  logic [7:0]  peak_reg;
  logic        core_rst;
  logic        prev_clk_reg;
  logic        prev_clk_next;
  logic [5:0]  pos_reg;
  logic [5:0]  pos_next;
  sesq_mode_t  mode_reg;
  sesq_mode_t  mode_next;
  sesq_mode_t  mode_now;
  logic        rise;
  logic        fall;
  logic        step_ev;
  logic [5:0]  step_amt;

  // Edge detect; direction and mode are trusted stable near edges
  always_comb begin
    core_rst      = !aresetn || !rstpin_n_s || soft_rst_reg;
    rise          = clk_s && !prev_clk_reg;
    fall          = !clk_s && prev_clk_reg;
    mode_now      = decode_mode(edge_s, hi_s, lo_s);
    step_amt      = step_of(mode_now);
    step_ev       = en_s && (rise || (fall && !edge_s));
    prev_clk_next = clk_s;  // Tracks while disabled, so re-enable makes no phantom step
    pos_next      = pos_reg;
    mode_next     = en_s ? mode_now : mode_reg;
    if (step_ev) begin
      pos_next = dir_s ? pos_reg - step_amt : pos_reg + step_amt;
    end
    if (core_rst) begin
      pos_next  = HOME_POS;
      mode_next = EX_FULL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_clk_reg <= 1'b0;
      pos_reg      <= HOME_POS;
      mode_reg     <= EX_FULL;
    end else begin
      prev_clk_reg <= prev_clk_next;
      pos_reg      <= pos_next;
      mode_reg     <= mode_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive and current outputs

  logic [6:0] pa;
  logic [6:0] pb;
  logic       a_neg;
  logic       b_neg;
  logic [3:0] drive_reg;
  logic [3:0] drive_next;
  logic [6:0] pct_a_reg;
  logic [6:0] pct_a_next;
  logic [6:0] pct_b_reg;
  logic [6:0] pct_b_next;
  logic [7:0] cur_a_reg;
  logic [7:0] cur_a_next;
  logic [7:0] cur_b_reg;
  logic [7:0] cur_b_next;

  sesq_current_lut u_lut (
    .pos   (pos_reg),
    .mode  (mode_reg),
    .pct_a (pa),
    .pct_b (pb),
    .a_neg (a_neg),
    .b_neg (b_neg)
  );

  // Disabled means every winding off and no current demand
  always_comb begin
    pct_a_next = pa;
    pct_b_next = pb;
    drive_next = 4'h0;
    cur_a_next = 8'h00;
    cur_b_next = 8'h00;
    if (en_s && !core_rst) begin
      drive_next = {(pb != 7'h00) && b_neg, (pb != 7'h00) && !b_neg,
                    (pa != 7'h00) && a_neg, (pa != 7'h00) && !a_neg};
      cur_a_next = scale(peak_reg, pa);
      cur_b_next = scale(peak_reg, pb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_reg <= 4'h0;
      pct_a_reg <= 7'h00;
      pct_b_reg <= 7'h00;
      cur_a_reg <= 8'h00;
      cur_b_reg <= 8'h00;
    end else begin
      drive_reg <= drive_next;
      pct_a_reg <= pct_a_next;
      pct_b_reg <= pct_b_next;
      cur_a_reg <= cur_a_next;
      cur_b_reg <= cur_b_next;
    end
  end

  assign {drive_bb, drive_b, drive_ab, drive_a} = drive_reg;
  assign current_a_code = cur_a_reg;
  assign current_b_code = cur_b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; address and data may arrive in either order

  logic              aw_hold_reg, aw_hold_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic              w_hold_reg, w_hold_next;
  logic [7:0]        w_byte_reg, w_byte_next;
  logic              w_en_reg, w_en_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [1:0]        rresp_reg, rresp_next;
  logic              soft_rst_next;
  logic [7:0]        peak_next;

  always_comb begin
    s_axi_awready = !aw_hold_reg && !bvalid_reg;
    s_axi_wready  = !w_hold_reg && !bvalid_reg;
    s_axi_arready = !rvalid_reg;
    aw_hold_next  = aw_hold_reg || (s_axi_awvalid && s_axi_awready);
    aw_addr_next  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr_reg;
    w_hold_next   = w_hold_reg || (s_axi_wvalid && s_axi_wready);
    w_byte_next   = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[7:0] : w_byte_reg;
    w_en_next     = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : w_en_reg;
    bvalid_next   = bvalid_reg && !s_axi_bready;
    bresp_next    = bresp_reg;
    soft_rst_next = soft_rst_reg;
    peak_next     = peak_reg;
    // Commit once both halves are held; status words are read-only
    if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      case (aw_addr_reg)
        OFS_CTRL:    if (w_en_reg) soft_rst_next = w_byte_reg[0];
        OFS_PEAK:    if (w_en_reg) peak_next = w_byte_reg;
        OFS_STATUS:  bresp_next = RESP_OKAY;
        OFS_CURRENT: bresp_next = RESP_OKAY;
        default:     bresp_next = RESP_SLVERR;
      endcase
    end
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      case (s_axi_araddr)
        OFS_CTRL:    rdata_next = {31'h0, soft_rst_reg};
        OFS_PEAK:    rdata_next = {24'h0, peak_reg};
        OFS_STATUS:  rdata_next = {18'h0, dir_s, en_s, 1'b0, mode_reg, 2'h0, pos_reg};
        OFS_CURRENT: rdata_next = {17'h0, pct_b_reg, 1'b0, pct_a_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg  <= 1'b0;
      aw_addr_reg  <= '0;
      w_hold_reg   <= 1'b0;
      w_byte_reg   <= 8'h00;
      w_en_reg     <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h0;
      rresp_reg    <= RESP_OKAY;
      soft_rst_reg <= 1'b0;
      peak_reg     <= PEAK_RST;
    end else begin
      aw_hold_reg  <= aw_hold_next;
      aw_addr_reg  <= aw_addr_next;
      w_hold_reg   <= w_hold_next;
      w_byte_reg   <= w_byte_next;
      w_en_reg     <= w_en_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
      soft_rst_reg <= soft_rst_next;
      peak_reg     <= peak_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_fall_rise_only;
    en_s && edge_s && fall && !core_rst;
  endsequence

  a_rise_only_hold: assert property (s_fall_rise_only |=> $stable(pos_reg))
    else $error("position moved on a falling edge in rising-edge mode");
  a_both_edge_step: assert property (en_s && !edge_s && fall && !core_rst && !dir_s
    |=> pos_reg == 6'($past(pos_reg) + $past(step_amt)))
    else $error("falling edge did not step in both-edge mode");
  a_half_full_cur: assert property (mode_reg == EX_HALF100 && !core_rst
    |=> pct_a_reg == 7'h00 || pct_a_reg == 7'h64)
    else $error("half step at full current gave a reduced level");
  a_pseudo_micro: assert property (mode_reg == EX_HALFPM && pos_reg[3:0] == 4'h8
    |=> pct_a_reg == 7'h47 && pct_b_reg == 7'h47)
    else $error("pseudo-micro two-phase position is not 71 percent");
  a_sine_table: assert property (mode_reg == EX_SIXTEENTH && pos_reg == 6'h01
    |=> pct_b_reg == 7'h0B && pct_a_reg == 7'h64)
    else $error("first sixteenth did not give 11 and 100 percent");
  a_enable_off: assert property (!en_s |=> drive_reg == 4'h0 ##1 drive_reg == 4'h0 || en_s)
    else $error("drive active while disabled");
  a_peak_scale: assert property ($past(en_s) && !$past(core_rst) && pct_a_reg == 7'h64
    |-> cur_a_reg == $past(peak_reg))
    else $error("full level differs from the peak code");
  a_dir_reverse: assert property (step_ev && dir_s && !core_rst
    |=> pos_reg == 6'($past(pos_reg) - $past(step_amt)))
    else $error("reverse direction did not step backward");
  a_hold_disabled: assert property (!en_s && !core_rst |=> $stable(pos_reg))
    else $error("position changed while disabled");
  a_reset_home: assert property (disable iff (1'b0) core_rst |=> pos_reg == HOME_POS)
    else $error("reset did not return the position home");

endmodule

// file: logic/sesq_pkg.sv
/*
 * Shared constants and types of the stepper excitation sequencer: register map,
 * reset values, position arithmetic and excitation modes.
 * Assumes nothing of its surroundings; imported by sesq_top and sesq_current_lut.
 */
package sesq_pkg;

  // AXI4-Lite register map, byte addresses
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  OFS_CTRL    = 4'h0;  // [0] soft reset of the sequencer
  localparam logic [3:0]  OFS_PEAK    = 4'h4;  // [7:0] motor_peak_current code
  localparam logic [3:0]  OFS_STATUS  = 4'h8;  // position, mode, pin levels
  localparam logic [3:0]  OFS_CURRENT = 4'hC;  // chopper percentages of both phases

  // Field positions inside STATUS and CURRENT
  localparam int          ST_MODE_LSB = 8;
  localparam int          ST_EN_BIT   = 12;
  localparam int          ST_DIR_BIT  = 13;
  localparam int          CUR_B_LSB   = 8;

  // Reset values
  localparam logic [7:0]  PEAK_RST    = 8'hFF;
  localparam logic [5:0]  HOME_POS    = 6'h08;  // Both phases on, first quadrant

  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Percentages of the software-set peak code
  localparam logic [6:0]  PCT_FULL    = 7'h64;  // 100 percent
  localparam logic [6:0]  PCT_DIV     = 7'h64;

  // Position counts in sixteenths of a quadrant
  localparam logic [5:0]  STEP_FULL   = 6'h10;
  localparam logic [5:0]  STEP_HALF   = 6'h08;
  localparam logic [5:0]  STEP_QUART  = 6'h04;
  localparam logic [5:0]  STEP_EIGHT  = 6'h02;
  localparam logic [5:0]  STEP_SIXT   = 6'h01;
  localparam logic [4:0]  QUAD_SPAN   = 5'h10;
  localparam int          SYNC_W      = 7;

  typedef enum logic [2:0] {
    EX_FULL,       // Two phases on, full current
    EX_HALF100,    // Half step, full current everywhere
    EX_HALFPM,     // Half step, pseudo-micro 100/71
    EX_QUARTER,
    EX_EIGHTH,
    EX_SIXTEENTH
  } sesq_mode_t;

endpackage

// file: logic/sesq_sync.sv
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes each bit is an independent level; no bus coherence is promised.
 */
`timescale 1ns/1ns
module sesq_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,     // System clock
  input  wire logic         aresetn,  // Synchronous reset, low active
  input  wire logic [W-1:0] din,      // Asynchronous levels
  output logic      [W-1:0] dout      // Synchronised levels
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  // Next values; the first stage feeds only the second
  always_comb begin
    meta_next = din;
    sync_next = meta_reg;
  end

  // Both stages clear to zero so that a held reset pin reads as asserted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg;
endmodule

// file: logic/sesq_current_lut.sv
/*
 * Maps the excitation position and mode to per-phase chopper percentages
 * and phase polarities. Purely combinational.
 * Assumes the position counts sixteenths of a quadrant, four quadrants a turn.
 */
`timescale 1ns/1ns
module sesq_current_lut
  import sesq_pkg::*;
(
  input  wire logic [5:0]        pos,    // Electrical position
  input  wire sesq_pkg::sesq_mode_t mode, // Latched excitation mode
  output logic      [6:0]        pct_a,  // Phase A percentage
  output logic      [6:0]        pct_b,  // Phase B percentage
  output logic                   a_neg,  // Phase A drives its complement winding
  output logic                   b_neg   // Phase B drives its complement winding
);
  // Sine table in sixteenths of a quadrant; zero angle means no current
  function automatic logic [6:0] sine_pct(input logic [4:0] th);
    case (th)
      5'h01:   sine_pct = 7'h0B;
      5'h02:   sine_pct = 7'h14;
      5'h03:   sine_pct = 7'h1E;
      5'h04:   sine_pct = 7'h28;
      5'h05:   sine_pct = 7'h2F;
      5'h06:   sine_pct = 7'h37;
      5'h07:   sine_pct = 7'h40;
      5'h08:   sine_pct = 7'h47;
      5'h09:   sine_pct = 7'h4D;
      5'h0A:   sine_pct = 7'h53;
      5'h0B:   sine_pct = 7'h57;
      5'h0C:   sine_pct = 7'h5D;
      5'h0D:   sine_pct = 7'h5F;
      5'h0E:   sine_pct = 7'h61;
      5'h0F:   sine_pct = 7'h64;
      5'h10:   sine_pct = 7'h64;
      default: sine_pct = 7'h00;
    endcase
  endfunction

  // Full-current modes flatten every energised phase to the peak
  function automatic logic [6:0] shape(input logic [6:0] p, input sesq_mode_t m);
    if ((m == EX_FULL || m == EX_HALF100) && p != 7'h00) begin
      shape = PCT_FULL;
    end else begin
      shape = p;
    end
  endfunction

  logic [4:0] k;
  logic [4:0] th_a;
  logic [4:0] th_b;

  // Odd quadrants swap the cosine and sine roles
  always_comb begin
    k     = {1'b0, pos[3:0]};
    th_a  = pos[4] ? k : QUAD_SPAN - k;
    th_b  = pos[4] ? QUAD_SPAN - k : k;
    pct_a = shape(sine_pct(th_a), mode);
    pct_b = shape(sine_pct(th_b), mode);
    a_neg = pos[5] ^ pos[4];
    b_neg = pos[5];
  end
endmodule

// file: verif/sesq_ctrl_model.sv
/* Motion controller model: drives step clock, direction and mode pins.
   Assumes a 20 MHz aclk, so 140 cycles cover the 7 us hold window. */
`timescale 1ns/1ns
module sesq_ctrl_model (
  input  wire logic       aclk,      // System clock
  output logic            step_clk,  // Step clock pin
  output logic            dir,       // Direction pin
  output logic [2:0]      code       // Edge select, mode high, mode low
);
  // Pins start at rest in full-step mode
  initial begin
    step_clk = 1'b0;
    dir      = 1'b0;
    code     = 3'h4;
  end
  // One whole pulse; both edges stay clear of any pin change
  task automatic pulse(input logic d, input logic [2:0] c);
    @(posedge aclk);
    dir  <= d;
    code <= c;
    repeat (140) @(posedge aclk);
    step_clk <= 1'b1;
    repeat (200) @(posedge aclk);
    step_clk <= 1'b0;
    repeat (200) @(posedge aclk);
  endtask
endmodule

// file: verif/tb_sesq_top.sv
/* Self-checking bench: AXI4-Lite master, pin stimulus and read scoreboard.
   Assumes the controller model owns step, direction and mode pins. */
`timescale 1ns/1ns
module tb_sesq_top;
  import sesq_pkg::*;
  localparam logic [6:0] PT [0:16] = '{7'h00, 7'h0B, 7'h14, 7'h1E, 7'h28, 7'h2F, 7'h37,
    7'h40, 7'h47, 7'h4D, 7'h53, 7'h57, 7'h5D, 7'h5F, 7'h61, 7'h64, 7'h64};
  localparam sesq_mode_t MD [0:7] = '{EX_HALFPM, EX_QUARTER, EX_EIGHTH, EX_SIXTEENTH,
    EX_FULL, EX_HALF100, EX_QUARTER, EX_EIGHTH};
  logic        aclk = 1'b0, aresetn = 1'b0, en = 1'b1, rst_n = 1'b1;
  logic        stp, dir, da, dab, db, dbb, awr, wrdy, bv, arr, rv;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [2:0]  code;
  logic [7:0]  ca, cb, peak;
  logic [3:0]  awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0]  bresp, rresp;
  logic [33:0] q[$];
  logic [5:0]  pos_m;
  sesq_mode_t  md_m;
  int          n_mismatch = 0, num_checks = 0;
  always #25 aclk = ~aclk;
  sesq_ctrl_model u_sesq_ctrl_model (.aclk(aclk), .step_clk(stp), .dir(dir), .code(code));
  sesq_top u_sesq_top (.aclk(aclk), .aresetn(aresetn), .step_clock_in(stp),
    .rotation_direction_in(dir), .mode_sel_low_bit(code[0]), .mode_sel_high_bit(code[1]),
    .edge_select_bit(code[2]), .output_enable_in(en), .system_reset_n_in(rst_n),
    .drive_a(da), .drive_ab(dab), .drive_b(db), .drive_bb(dbb), .current_a_code(ca),
    .current_b_code(cb), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tmo();
    n_mismatch++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    wrap_up();
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    for (int i = 0; i < 100 && !done; i++) begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv && br) begin
        done = 1'b1;
        br <= 1'b0;
        chk({bresp, 32'h0}, {RESP_OKAY, 32'h0});
      end
    end
    if (!done) tmo();
  endtask
  // The note goes on the queue first; the monitor compares the answer
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    logic done;
    done = 1'b0;
    q.push_back(e);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    for (int i = 0; i < 100 && !done; i++) begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      if (rv && rr) begin
        done = 1'b1;
        rr <= 1'b0;
      end
    end
    if (!done) tmo();
  endtask
  // Read data monitor; an empty queue expects an impossible value
  always @(posedge aclk) begin
    if (rv === 1'b1 && rr) chk({rresp, rdat}, q.size() != 0 ? q.pop_front() : 34'h3_0000_0000);
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] pc(input logic [4:0] ang);
    return (ang != 5'h0 && md_m inside {EX_FULL, EX_HALF100}) ? PCT_FULL : PT[ang];
  endfunction
  function automatic logic [33:0] st_exp();
    logic [33:0] e;
    e = 34'h0;
    e[5:0] = pos_m;
    e[10:8] = md_m;
    e[12] = en;
    e[13] = dir;
    return e;
  endfunction
  // Steps per pulse times step size: both edges step when edge select is low
  function automatic logic [5:0] adv(input int c);
    logic [5:0] s;
    case (MD[c])
      EX_FULL: s = STEP_FULL;
      EX_HALF100, EX_HALFPM: s = STEP_HALF;
      EX_QUARTER: s = STEP_QUART;
      EX_EIGHTH: s = STEP_EIGHT;
      default: s = STEP_SIXT;
    endcase
    return (c >= 4) ? s : 6'(s * 2);
  endfunction
  task automatic chk_all();
    logic [4:0]  aa;
    logic [33:0] c;
    logic [1:0]  qd;
    logic [3:0]  dx;
    aa = pos_m[4] ? {1'b0, pos_m[3:0]} : 5'h10 - {1'b0, pos_m[3:0]};
    c = {19'h0, pc(5'h10 - aa), 1'b0, pc(aa)};
    rd(OFS_STATUS, st_exp());
    rd(OFS_CURRENT, c);
    chk({26'h0, ca}, {26'h0, 8'((16'(peak) * c[6:0]) / 100)});
    chk({26'h0, cb}, {26'h0, 8'((16'(peak) * c[14:8]) / 100)});
    // Winding polarity by quadrant: A reversed in quadrants 1 and 2, B in 2 and 3
    qd = pos_m[5:4];
    dx = {c[6:0] != 7'h0 && qd[1] == qd[0], c[6:0] != 7'h0 && qd[1] != qd[0],
          c[14:8] != 7'h0 && !qd[1], c[14:8] != 7'h0 && qd[1]};
    chk({30'h0, da, dab, db, dbb}, {30'h0, dx});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic d;
    int   n;
    void'($urandom(58061));
    peak = PEAK_RST;
    pos_m = HOME_POS;
    md_m = EX_FULL;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (200) @(posedge aclk);
    rd(OFS_PEAK, {RESP_OKAY, 24'h0, PEAK_RST});
    rd(4'h2, {RESP_SLVERR, 32'h0});
    chk_all();
    peak = 8'($urandom_range(40, 255));
    wr(OFS_PEAK, {24'h0, peak});
    // Every mode code, random direction and pulse count
    for (int c = 0; c < 8; c++) begin
      d = 1'($urandom);
      n = $urandom_range(1, 4);
      md_m = MD[c];
      repeat (n) begin
        u_sesq_ctrl_model.pulse(d, 3'(c));
        pos_m = d ? pos_m - adv(c) : pos_m + adv(c);
      end
      chk_all();
    end
    // Disabled: drives off, a pulse and a mode change are ignored
    en <= 1'b0;
    repeat (10) @(posedge aclk);
    chk({30'h0, da, dab, db, dbb}, 34'h0);
    chk({18'h0, ca, cb}, 34'h0);
    u_sesq_ctrl_model.pulse(dir, 3'h4);
    rd(OFS_STATUS, st_exp());
    en <= 1'b1;
    md_m = EX_FULL;
    repeat (10) @(posedge aclk);
    chk_all();
    // Reset pin sends the position home
    rst_n <= 1'b0;
    repeat (10) @(posedge aclk);
    chk({18'h0, ca, cb}, 34'h0);
    pos_m = HOME_POS;
    rst_n <= 1'b1;
    repeat (200) @(posedge aclk);
    chk_all();
    // Soft reset bit acts as the pin does, so move away from home first
    u_sesq_ctrl_model.pulse(1'b0, 3'h4);
    pos_m = pos_m + STEP_FULL;
    chk_all();
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CTRL, {RESP_OKAY, 32'h1});
    chk({18'h0, ca, cb}, 34'h0);
    wr(OFS_CTRL, 32'h0);
    pos_m = HOME_POS;
    repeat (10) @(posedge aclk);
    chk_all();
    wrap_up();
  end
endmodule
